// >>> src/ccmd_pkg.sv
package ccmd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_CHOPPER_CONFIGURATION = 8'h00;
  localparam logic [7:0]  ADR_STATUS                = 8'h04;
  localparam int          ADR_W                     = 8;

  // ----------------------------------------------------------------
  // chopper_configuration field layout
  // ----------------------------------------------------------------
  localparam int          BIT_PROTECT_DIS = 30;
  localparam int          BIT_DOUBLE_EDGE = 29;
  localparam int          BIT_INTERPOLATE = 28;
  localparam int          MRES_HI         = 27;
  localparam int          MRES_LO         = 24;
  localparam int          BIT_HV_CHOPPER  = 19;
  localparam int          BIT_HV_FULLSTEP = 18;
  localparam int          CHOPPER_OFF_TIME_HI         = 3;
  localparam int          CHOPPER_OFF_TIME_LO         = 0;
  // bit 31 and bits 23:20 are reserved and read as zero
  localparam logic [31:0] CFG_WR_MASK     = 32'h7f0f_ffff;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // status layout
  // ----------------------------------------------------------------
  localparam int          ST_MSCNT_HI     = 9;
  localparam int          ST_FULLSTEP     = 16;
  localparam int          ST_HV_CHOPPER   = 17;
  localparam int          ST_INTERP_BUSY  = 18;

  // ----------------------------------------------------------------
  // microstep decode
  // ----------------------------------------------------------------
  localparam logic [3:0]  MRES_NATIVE     = 4'h0;
  localparam logic [3:0]  MRES_16         = 4'h4;
  localparam logic [3:0]  MRES_FULL       = 4'h8;
  localparam logic [8:0]  WIDTH_ONE       = 9'h001;
  localparam logic [4:0]  INTERP_STEPS    = 5'h10;
  localparam logic [7:0]  POS_45DEG       = 8'h80;
  localparam int          MSCNT_W         = 10;

endpackage

// >>> src/ccmd_chopper_decode.sv
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// RULE1 - bit 30 set disables ground-short detection
// RULE2 - double-edge: both step edges advance position
// RULE3 - controller uses double-edge only with step/dir
// RULE4 - interpolation spreads 16-microstep steps into 256
// RULE5 - resolution code zero means native 256 microsteps
// RULE6 - codes one to eight: 128 down to fullstep
// RULE7 - controller changes coarse resolution at suitable position; this code applies a new resolution code at once, at any position
// RULE8 - high-velocity chopper switch doubles off time
// RULE9 - high-velocity fullstep entered only at 45 degrees
// RULE10 - software writes zero to reserved bits
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
module ccmd_chopper_decode
  import ccmd_pkg::*;
#(
  parameter int DAT_W = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  input  wire logic             step_i,
  input  wire logic             dir_i,
  input  wire logic             velocity_high_i,
  output logic                  s2g_detect_en_o,
  output logic                  chopper_hv_mode_o,
  output logic      [4:0]       chopper_off_time_o,
  output logic                  fullstep_active_o,
  output logic                  microstep_adv_o,
  output logic      [MSCNT_W-1:0] mscnt_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [31:0]        cfg_r;
  logic [31:0]        cfg_nxt;
  logic               ack_r;
  logic [DAT_W-1:0]   rdat_r;
  logic [DAT_W-1:0]   rdat_nxt;
  wire                bus_req_w  = cyc_i && stb_i && !ack_r;
  wire                hit_cfg_w  = adr_i == ADR_CHOPPER_CONFIGURATION;
  wire                hit_st_w   = adr_i == ADR_STATUS;
  wire                wr_cfg_w   = bus_req_w && we_i && hit_cfg_w;
  wire        [31:0]  sel_mask_w = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // ack is registered, so each access costs exactly one wait state
  // a held strobe is not taken again while ack is high, so no double ack
  // reserved bits are masked out so they always read back as zero
  assign cfg_nxt = wr_cfg_w ?
                   ((cfg_r & ~sel_mask_w) | (dat_i & sel_mask_w)) & CFG_WR_MASK : cfg_r;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  // fields come straight from the stored word; a write acts one cycle later
  wire        diss_w    = cfg_r[BIT_PROTECT_DIS];
  wire        dedge_w   = cfg_r[BIT_DOUBLE_EDGE];
  wire        intpol_w  = cfg_r[BIT_INTERPOLATE];
  wire [3:0]  mres_w    = cfg_r[MRES_HI:MRES_LO];
  wire        hvchm_w   = cfg_r[BIT_HV_CHOPPER];
  wire        hvfs_w    = cfg_r[BIT_HV_FULLSTEP];
  wire [3:0]  chopper_off_time_w    = cfg_r[CHOPPER_OFF_TIME_HI:CHOPPER_OFF_TIME_LO];

  // ----------------------------------------------------------------
  // step edge detection
  // ----------------------------------------------------------------
  // step_i is taken as synchronous, so one register detects its edges
  // reset value matches the idle low level so no false edge follows reset
  logic       step_d_r;
  logic       dir_r;
  wire        rise_w     = step_i && !step_d_r;
  wire        fall_w     = !step_i && step_d_r;
  // falling edges count only when double-edge stepping is enabled
  wire        step_evt_w = rise_w || (dedge_w && fall_w); // see RULE2

  // ----------------------------------------------------------------
  // resolution and interpolation
  // ----------------------------------------------------------------
  logic                fs_r;
  logic                fs_nxt;
  logic [4:0]          pend_r;
  logic [4:0]          pend_nxt;
  logic [MSCNT_W-1:0]  pos_r;
  logic [MSCNT_W-1:0]  pos_nxt;
  logic                adv_nxt;
  // codes above eight are clamped to full step
  wire  [3:0]          mres_eff_w = (mres_w > MRES_FULL) ? MRES_FULL : mres_w;
  wire  [3:0]          mres_use_w = fs_r ? MRES_FULL : mres_eff_w;
  wire  [8:0]          width_w    = WIDTH_ONE << mres_use_w; // see RULE5 see RULE6
  wire                 interp_w   = intpol_w && (mres_w == MRES_16) && !fs_r; // see RULE4
  wire                 hv_w       = velocity_high_i;
  wire  [MSCNT_W-1:0]  pend_ext_w = {{(MSCNT_W-5){1'b0}}, pend_r};
  wire  [MSCNT_W-1:0]  one_w      = {{(MSCNT_W-1){1'b0}}, 1'b1};
  wire  [MSCNT_W-1:0]  wid_ext_w  = {{(MSCNT_W-9){1'b0}}, width_w};
  wire                 at_45_w    = pos_r[7:0] == POS_45DEG;

  // substeps use the direction latched at their own step edge
  // an interrupted interpolation is caught up at once before a new interpolated step; any other step drops it
  always_comb begin
    pos_nxt  = pos_r;
    pend_nxt = pend_r;
    adv_nxt  = 1'b0;
    if (step_evt_w && interp_w) begin
      pos_nxt  = dir_r ? pos_r - pend_ext_w : pos_r + pend_ext_w; // see RULE4
      pend_nxt = INTERP_STEPS;
      adv_nxt  = pend_r != 5'h00;
    end else if (step_evt_w) begin
      pos_nxt  = dir_i ? pos_r - wid_ext_w : pos_r + wid_ext_w; // see RULE2 see RULE6
      pend_nxt = 5'h00;
      adv_nxt  = 1'b1;
    end else if (pend_r != 5'h00) begin
      pos_nxt  = dir_r ? pos_r - one_w : pos_r + one_w;
      pend_nxt = pend_r - 5'h01;
      adv_nxt  = 1'b1;
    end
  end

  // fullstep is entered and left only at the 45 degree position
  assign fs_nxt = at_45_w ? (hvfs_w && hv_w) : fs_r; // see RULE9

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped offsets read as zero but are still acknowledged
  wire [31:0] status_w = {13'h0000, pend_r != 5'h00, chopper_hv_mode_o, fs_r,
                          {(16-MSCNT_W){1'b0}}, pos_r};
  assign rdat_nxt = !bus_req_w || we_i ? {DAT_W{1'b0}} :
                    hit_cfg_w ? cfg_r :
                    hit_st_w  ? status_w : {DAT_W{1'b0}};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r    <= CFG_RESET;
      ack_r    <= 1'b0;
      rdat_r   <= {DAT_W{1'b0}};
    end else if (ce_i) begin
      // the bus side freezes with ce_i low just like the step side
      cfg_r    <= cfg_nxt;
      ack_r    <= bus_req_w;
      rdat_r   <= rdat_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_d_r <= 1'b0;
      dir_r    <= 1'b0;
      pos_r    <= {MSCNT_W{1'b0}};
      pend_r   <= 5'h00;
      fs_r     <= 1'b0;
    end else if (ce_i) begin
      step_d_r <= step_i;
      dir_r    <= step_evt_w ? dir_i : dir_r;
      pos_r    <= pos_nxt;
      pend_r   <= pend_nxt;
      fs_r     <= fs_nxt;
    end
  end

  // outputs come straight from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s2g_detect_en_o    <= 1'b1;
      chopper_hv_mode_o  <= 1'b0;
      chopper_off_time_o <= 5'h00;
      microstep_adv_o    <= 1'b0;
    end else if (ce_i) begin
      s2g_detect_en_o    <= !diss_w; // see RULE1
      chopper_hv_mode_o  <= hvchm_w && hv_w; // see RULE8
      // doubled off time keeps the chopper frequency from doubling
      chopper_off_time_o <= (hvchm_w && hv_w) ? {chopper_off_time_w, 1'b0} : {1'b0, chopper_off_time_w}; // see RULE8
      // adv marks the clock in which the new position shows
      microstep_adv_o    <= adv_nxt;
    end
  end

  assign ack_o             = ack_r;
  assign dat_o             = rdat_r;
  assign mscnt_o           = pos_r;
  assign fullstep_active_o = fs_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_protect_follow_bit: assert property (ce_i |=> s2g_detect_en_o == !$past(diss_w)) // see RULE1
    else $error("ground-short detect enable does not follow bit 30");

  a_dedge_fall_step: assert property ( // see RULE2
    ce_i && dedge_w && fall_w && !interp_w |=> microstep_adv_o && pos_r != $past(pos_r))
    else $error("falling step edge ignored with double-edge set");

  a_single_edge_only: assert property (ce_i && !dedge_w && fall_w |-> !step_evt_w) // see RULE2
    else $error("falling step edge counted without double-edge");

  a_interp_load_run: assert property ( // see RULE4
    ce_i && step_evt_w && interp_w |=> pend_r == INTERP_STEPS)
    else $error("interpolation did not load sixteen substeps");

  a_native_width_one: assert property ( // see RULE5
    step_evt_w && mres_w == MRES_NATIVE && !fs_r |-> width_w == WIDTH_ONE)
    else $error("native resolution step width is not one");

  a_width_decode_pow: assert property ( // see RULE6
    step_evt_w && !fs_r && mres_w <= MRES_FULL |->
      (width_w << (MRES_FULL - mres_w)) == (WIDTH_ONE << MRES_FULL))
    else $error("step width does not match resolution code");

  a_off_time_double: assert property ( // see RULE8
    ce_i && hvchm_w && hv_w |=> chopper_off_time_o == {$past(chopper_off_time_w), 1'b0})
    else $error("off time not doubled in high-velocity chopper mode");

  a_fullstep_at_45: assert property ( // see RULE9
    ce_i && fs_nxt != fs_r |-> at_45_w)
    else $error("fullstep switched away from the 45 degree position");

  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("bus ack held longer than one cycle");

  a_ack_after_req: assert property (
    ce_i && bus_req_w |=> ack_o)
    else $error("bus request not acknowledged in the next cycle");

  a_idle_data_zero: assert property (
    !ack_o |-> dat_o == {DAT_W{1'b0}})
    else $error("read data not zero outside an acknowledge");

  a_ce_freeze_state: assert property (
    !ce_i |=> $stable(pos_r) && $stable(cfg_r))
    else $error("state changed while clock enable was low");

  // ----------------------------------------------------------------
  // step assertions
  // ----------------------------------------------------------------
  a_dir_sample_step: assert property ( // see RULE2
    ce_i && step_evt_w |=> dir_r == $past(dir_i))
    else $error("direction not latched on the step edge");

  a_native_step_up: assert property ( // see RULE5
    ce_i && step_evt_w && !fs_r && mres_w == MRES_NATIVE && !dir_i |=> pos_r == $past(pos_r) + one_w)
    else $error("native step up did not move by one");

  a_native_step_down: assert property ( // see RULE5
    ce_i && step_evt_w && !fs_r && mres_w == MRES_NATIVE && dir_i |=> pos_r == $past(pos_r) - one_w)
    else $error("native step down did not move by one");

  a_full_step_up: assert property ( // see RULE6
    ce_i && step_evt_w && mres_eff_w == MRES_FULL && !dir_i |=>
      pos_r == $past(pos_r) + (10'(WIDTH_ONE) << MRES_FULL))
    else $error("full step did not move by a whole table quarter");

  // ----------------------------------------------------------------
  // interpolation assertions
  // ----------------------------------------------------------------
  a_interp_walk_one: assert property ( // see RULE4
    ce_i && !step_evt_w && pend_r != 5'h00 |=> pend_r == $past(pend_r) - 5'h01 && microstep_adv_o)
    else $error("interpolation substep did not advance by one");

  a_interp_only_16: assert property ( // see RULE4
    ce_i && step_evt_w && mres_w != MRES_16 |=> pend_r == 5'h00)
    else $error("interpolation started outside sixteen microstep mode");

  a_pend_bound_max: assert property ( // see RULE4
    pend_r <= INTERP_STEPS)
    else $error("pending substeps above sixteen");

  // ----------------------------------------------------------------
  // chopper assertions
  // ----------------------------------------------------------------
  a_hv_mode_follow: assert property ( // see RULE8
    ce_i |=> chopper_hv_mode_o == $past(hvchm_w && hv_w))
    else $error("high-velocity chopper mode does not follow its inputs");

  a_off_time_plain: assert property ( // see RULE8
    ce_i && !(hvchm_w && hv_w) |=> chopper_off_time_o == {1'b0, $past(chopper_off_time_w)})
    else $error("off time changed outside high-velocity chopper mode");

  a_fullstep_needs_hv: assert property ( // see RULE9
    ce_i && !fs_r && fs_nxt |-> hvfs_w && hv_w)
    else $error("fullstep entered without enable and high velocity");

  c_dedge_fall: cover property (ce_i && dedge_w && fall_w);
  c_interp_run: cover property (ce_i && interp_w && step_evt_w ##1 pend_r != 5'h00);
  c_fullstep_enter: cover property (ce_i && !fs_r && fs_nxt);
  c_cfg_write: cover property (wr_cfg_w && ce_i);
  c_status_read: cover property (ce_i && bus_req_w && !we_i && hit_st_w);

endmodule // ccmd_chopper_decode

// >>> sim/ccmd_step_src.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// step/direction source
// ----------------------------------------------------------------
module ccmd_step_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       down_i,
  input  wire logic [3:0] hold_i,
  output logic            step_o,
  output logic            dir_o
);
  logic [3:0] cnt_r;
  // only ever a step/dir source, never beside a ramp generator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_o <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (go_i) begin
      step_o <= 1'b1;
      cnt_r  <= hold_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      step_o <= 1'b0;
    end
  end
  // direction is held over both edges so a double-edge step sees one value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_o <= 1'b0;
    end else if (go_i) begin
      dir_o <= down_i;
    end
  end
endmodule // ccmd_step_src

// >>> sim/ccmd_chopper_decode_tb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module ccmd_chopper_decode_tb;
  import ccmd_pkg::*;
  logic               clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic               go = 1'b0, down = 1'b0, vh = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [3:0]         hold = 4'h0;
  logic [31:0]        wdat = 32'h0, rd, dat;
  logic               ack, step, dir, s2g, hvm, fsa, adv;
  logic [4:0]         chopper_off_time;
  logic [MSCNT_W-1:0] ms, pos;
  int                 err_count = 0, n_checks = 0;
  always #50 clk_i = ~clk_i;
  ccmd_chopper_decode dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat),
    .ack_o(ack), .step_i(step), .dir_i(dir), .velocity_high_i(vh), .s2g_detect_en_o(s2g),
    .chopper_hv_mode_o(hvm), .chopper_off_time_o(chopper_off_time), .fullstep_active_o(fsa),
    .microstep_adv_o(adv), .mscnt_o(ms));
  ccmd_step_src src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .down_i(down),
    .hold_i(hold), .step_o(step), .dir_o(dir));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 40) begin
      err_count++;
      finish_test();
    end
  endtask
  // one classic cycle; a wait that never sees ack ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    tmo(i);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic stp(input logic dn, input logic [3:0] h);
    int i;
    down <= dn;
    hold <= h;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (i = 0; i < 40 && adv !== 1'b1; i++) @(posedge clk_i);
    tmo(i);
    repeat (h + 4) @(posedge clk_i);
  endtask
  task automatic cfg(input logic [31:0] d);
    wb(1'b1, ADR_CHOPPER_CONFIGURATION, d);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(s2g), 32'h1);
    wb(1'b0, ADR_CHOPPER_CONFIGURATION, 32'h0);
    chk(rd, CFG_RESET);
    cfg(32'hffff_ffff);
    wb(1'b0, ADR_CHOPPER_CONFIGURATION, 32'h0);
    chk(rd, CFG_WR_MASK);
    chk(32'(s2g), 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    pos = '0;
    // coarse first: each change lands on a multiple of the new width
    for (int c = 8; c >= 0; c--) begin
      cfg(32'(c) << MRES_LO);
      stp(1'b0, 4'h0);
      pos += 10'(1 << c);
      chk(32'(ms), 32'(pos));
    end
    cfg(32'h0);
    stp(1'b0, 4'h0);
    pos += 10'h1;
    cfg((32'h7 << MRES_LO) | (32'h1 << BIT_HV_FULLSTEP));
    vh <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(fsa), 32'h0);
    stp(1'b0, 4'h0);
    pos += 10'h080;
    chk(32'(fsa), 32'h1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk(rd & 32'h1_03ff, 32'h1_0000 | 32'(pos));
    vh <= 1'b0;
    cfg((32'h1 << BIT_HV_CHOPPER) | 32'h5);
    vh <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({26'h0, hvm, chopper_off_time}, {26'h0, 1'b1, 5'h0a});
    vh <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({26'h0, hvm, chopper_off_time}, {26'h0, 1'b0, 5'h05});
    cfg(32'h1 << BIT_DOUBLE_EDGE);
    stp(1'b1, 4'h3);
    pos -= 10'h2;
    chk(32'(ms), 32'(pos));
    cfg((32'h1 << BIT_INTERPOLATE) | (32'(MRES_16) << MRES_LO));
    stp(1'b0, 4'h0);
    chk(32'(10'(ms - pos) < 10'h010), 32'h1);
    repeat (20) @(posedge clk_i);
    pos += 10'h010;
    chk(32'(ms), 32'(pos));
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule // ccmd_chopper_decode_tb
